// [wcg_pkg.sv]
// Constants and types shared by the compare waveform channel design.
//
// Overview of operation
// - Channel events fire on timer equals compare.
// - Four waveform kinds selected per channel.
// - Kind code 000b selects single-phase output.
// - Single-phase: output goes high on match.
// - Single-phase: output goes low at zero.
// - Initial level bit sets starting output level.
// - Polarity flip complements the generated waveform.
// - Polarity flip is the final output stage.
// - Free-running single-phase period is 65536 counts.
// - Channel 0 match clears timer, period n+2.
// - Compare at least n+2 keeps output low.
// - Channel on bit starts and stops output.
// - Every match sets the channel match flag.
// - Inverted kind toggles output on every match.
// - Free-running inverted level lasts 65536 counts.
// - Cleared-timer inverted level lasts n+2 counts.
// - Compare at least n+2 never toggles.
// - Refresh timing picks when compare goes active.
`default_nettype none
package wcg_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int CHAN_N = 8;
  localparam int GROUP_N = 2;
  localparam int KIND_W = 3;
  localparam int CLEAR_W = 3;
  localparam int INDEX_W = 3;

  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  localparam logic [KIND_W-1:0] KIND_SINGLE = 3'h0;
  localparam logic [KIND_W-1:0] KIND_TOGGLE = 3'h1;
  localparam logic [KIND_W-1:0] KIND_SETRESET = 3'h2;
  localparam logic [KIND_W-1:0] KIND_PHASE = 3'h3;
  localparam logic [CLEAR_W-1:0] CLEAR_FREE = 3'h0;
  localparam logic [CLEAR_W-1:0] CLEAR_ON_CH0 = 3'h2;
  localparam logic REFRESH_NOW = 1'h0;
  localparam logic REFRESH_AT_ZERO = 1'h1;
  localparam logic FUNC_WAVEFORM = 1'h0;

  // ----------------------------------------------------------------------
  // Reset values and fixed counts
  // ----------------------------------------------------------------------
  localparam logic [CNT_W-1:0] COUNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] COMPARE_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] TIMER_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] PHASE_STEP = 16'h0040;

  // ----------------------------------------------------------------------
  // Timer clear sequencing states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    WCG_CLR_IDLE = 3'b001,
    WCG_CLR_ARMED = 3'b010,
    WCG_CLR_WRAP = 3'b100
  } wcg_clr_state_type;

endpackage : wcg_pkg
`default_nettype wire

// [wcg_timer_if.sv]
// Interface between the base timer and the waveform channels of one group.
`timescale 1ns/10ps
`default_nettype none
interface wcg_timer_if;
  logic [15:0] count;
  logic count_strobe;
  logic ch0_match;

  modport timer (
    output count,
    output count_strobe,
    input ch0_match
  );

  modport chan (
    input count,
    input count_strobe
  );
endinterface : wcg_timer_if
`default_nettype wire

// [wcg_base_timer.sv]
// Shared 16-bit up counter of one channel group with channel 0 match clear.
`timescale 1ns/10ps
`default_nettype none
module wcg_base_timer (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Control
  input wire logic timer_run_in,
  input wire logic timer_tick_in,
  input wire logic [2:0] counter_clear_sel_in,
  // Channel side
  wcg_timer_if.timer tmr
);

  wcg_pkg::wcg_clr_state_type clr_state;
  wcg_pkg::wcg_clr_state_type next_clr_state;
  logic run_d;
  logic arm;
  logic [15:0] next_count;

  assign arm = tmr.ch0_match && (counter_clear_sel_in == wcg_pkg::CLEAR_ON_CH0);

  // The clear lands two counts after the match, so the period is n+2.
  always_comb begin
    next_clr_state = clr_state;
    next_count = tmr.count + wcg_pkg::COUNT_ONE;
    unique case (clr_state)
      wcg_pkg::WCG_CLR_IDLE: begin
        if (arm && timer_tick_in) begin
          next_clr_state = wcg_pkg::WCG_CLR_WRAP;
        end else if (arm) begin
          next_clr_state = wcg_pkg::WCG_CLR_ARMED;
        end
      end
      wcg_pkg::WCG_CLR_ARMED: begin
        if (timer_tick_in) begin
          next_clr_state = wcg_pkg::WCG_CLR_WRAP;
        end
      end
      wcg_pkg::WCG_CLR_WRAP: begin
        next_count = wcg_pkg::TIMER_ZERO;
        if (timer_tick_in) begin
          next_clr_state = wcg_pkg::WCG_CLR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      clr_state <= wcg_pkg::WCG_CLR_IDLE;
    end else if (!timer_run_in) begin
      clr_state <= wcg_pkg::WCG_CLR_IDLE;
    end else begin
      clr_state <= next_clr_state;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tmr.count <= wcg_pkg::COUNT_RESET;
      tmr.count_strobe <= 1'b0;
      run_d <= 1'b0;
    end else begin
      run_d <= timer_run_in;
      if (!timer_run_in) begin
        tmr.count <= wcg_pkg::COUNT_RESET;
        tmr.count_strobe <= 1'b0;
      end else if (timer_tick_in) begin
        tmr.count <= next_count;
        tmr.count_strobe <= 1'b1;
      end else begin
        tmr.count_strobe <= !run_d;
      end
    end
  end

endmodule : wcg_base_timer
`default_nettype wire

// [wcg_channel.sv]
// One compare waveform channel: compare shadow, match flag and output level.
`timescale 1ns/10ps
`default_nettype none
module wcg_channel (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Timer
  wcg_timer_if.chan tmr,
  // Configuration
  input wire logic [2:0] chan_index_in,
  input wire logic [15:0] compare_value_in,
  input wire logic compare_write_in,
  input wire logic [2:0] waveform_kind_sel_in,
  input wire logic initial_level_sel_in,
  input wire logic polarity_flip_in,
  input wire logic compare_refresh_timing_in,
  input wire logic function_pick_in,
  input wire logic channel_on_in,
  input wire logic partner_match_in,
  input wire logic irq_flag_clear_in,
  // Results
  output logic match_out,
  output logic match_irq_flag_out,
  output logic wave_out
);

  logic [15:0] active_cmp;
  logic [15:0] pending_cmp;
  logic pending_valid;
  logic active;
  logic zero_evt;
  logic phase_evt;
  logic level;
  logic next_level;
  logic [18:0] phase_wide;

  assign active = channel_on_in && (function_pick_in == wcg_pkg::FUNC_WAVEFORM);
  assign zero_evt = tmr.count_strobe && (tmr.count == wcg_pkg::TIMER_ZERO);
  assign phase_wide = 19'(chan_index_in) * 19'(wcg_pkg::PHASE_STEP);
  assign phase_evt = tmr.count_strobe && (tmr.count == phase_wide[15:0]);

  assign match_out = active && tmr.count_strobe && (tmr.count == active_cmp);

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      active_cmp <= wcg_pkg::COMPARE_RESET;
      pending_cmp <= wcg_pkg::COMPARE_RESET;
      pending_valid <= 1'b0;
    end else if (compare_write_in) begin
      pending_cmp <= compare_value_in;
      if (compare_refresh_timing_in == wcg_pkg::REFRESH_NOW) begin
        active_cmp <= compare_value_in;
        pending_valid <= 1'b0;
      end else begin
        pending_valid <= 1'b1;
      end
    end else if (pending_valid && (zero_evt || !active)) begin
      active_cmp <= pending_cmp;
      pending_valid <= 1'b0;
    end
  end

  // Timer values the count never reaches give no match, so outputs stay put.
  // Unreached compare holds.
  always_comb begin
    next_level = level;
    if (!active) begin
      next_level = initial_level_sel_in;
    end else begin
      unique case (waveform_kind_sel_in)
        wcg_pkg::KIND_SINGLE: begin
          if (match_out) begin
            next_level = 1'b1;
          end else if (zero_evt) begin
            next_level = 1'b0;
          end
        end
        wcg_pkg::KIND_TOGGLE: begin
          if (match_out) begin
            next_level = !level;
          end
        end
        wcg_pkg::KIND_SETRESET: begin
          if (match_out) begin
            next_level = 1'b1;
          end else if (partner_match_in || zero_evt) begin
            next_level = 1'b0;
          end
        end
        wcg_pkg::KIND_PHASE: begin
          if (match_out) begin
            next_level = 1'b0;
          end else if (phase_evt) begin
            next_level = 1'b1;
          end
        end
        default: begin
          next_level = level;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      level <= 1'b0;
      wave_out <= 1'b0;
    end else begin
      level <= next_level;
      wave_out <= next_level ^ polarity_flip_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      match_irq_flag_out <= 1'b0;
    end else if (match_out) begin
      match_irq_flag_out <= 1'b1;
    end else if (irq_flag_clear_in) begin
      match_irq_flag_out <= 1'b0;
    end
  end

endmodule : wcg_channel
`default_nettype wire

// [wcg_top.sv]
// Two groups of eight compare waveform channels, each with its base timer.
`timescale 1ns/10ps
`default_nettype none
module wcg_top (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Base timer control, per group
  input wire logic [1:0] timer_run_in,
  input wire logic [1:0] timer_tick_in,
  input wire logic [1:0][2:0] counter_clear_sel_in,
  // Channel configuration, per group and channel
  input wire logic [1:0][7:0][15:0] compare_value_in,
  input wire logic [1:0][7:0] compare_write_in,
  input wire logic [1:0][7:0][2:0] waveform_kind_sel_in,
  input wire logic [1:0][7:0] initial_level_sel_in,
  input wire logic [1:0][7:0] polarity_flip_in,
  input wire logic [1:0][7:0] compare_refresh_timing_in,
  input wire logic [1:0][7:0] function_pick_in,
  input wire logic [1:0][7:0] channel_on_in,
  input wire logic [1:0][7:0] irq_flag_clear_in,
  // Status
  output logic [1:0][15:0] timer_count_out,
  output logic [1:0][7:0] match_irq_flag_out,
  // Pins
  output logic [1:0][7:0] wave_out_pin_out
);

  // ----------------------------------------------------------------------
  // Groups
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < wcg_pkg::GROUP_N; g++) begin : g_group
    wcg_timer_if tmr_if ();
    logic [7:0] match;

    assign tmr_if.ch0_match = match[0];
    assign timer_count_out[g] = tmr_if.count;

    wcg_base_timer u_timer (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .timer_run_in(timer_run_in[g]),
      .timer_tick_in(timer_tick_in[g]),
      .counter_clear_sel_in(counter_clear_sel_in[g]),
      .tmr(tmr_if.timer)
    );

    // ----------------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------------
    for (genvar c = 0; c < wcg_pkg::CHAN_N; c++) begin : g_chan
      logic partner;

      // Only even channels pair with the next odd channel for set/reset.
      if (c % 2 == 0) begin : g_even
        assign partner = match[c + 1];
      end else begin : g_odd
        assign partner = 1'b0;
      end

      wcg_channel u_chan (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .tmr(tmr_if.chan),
        .chan_index_in(3'(c)),
        .compare_value_in(compare_value_in[g][c]),
        .compare_write_in(compare_write_in[g][c]),
        .waveform_kind_sel_in(waveform_kind_sel_in[g][c]),
        .initial_level_sel_in(initial_level_sel_in[g][c]),
        .polarity_flip_in(polarity_flip_in[g][c]),
        .compare_refresh_timing_in(compare_refresh_timing_in[g][c]),
        .function_pick_in(function_pick_in[g][c]),
        .channel_on_in(channel_on_in[g][c]),
        .partner_match_in(partner),
        .irq_flag_clear_in(irq_flag_clear_in[g][c]),
        .match_out(match[c]),
        .match_irq_flag_out(match_irq_flag_out[g][c]),
        .wave_out(wave_out_pin_out[g][c])
      );
    end
  end

endmodule : wcg_top
`default_nettype wire

// [wcg_load.sv]
// External load model that measures high time and level changes on every pin.
`timescale 1ns/10ps
`default_nettype none
module wcg_load (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Pins and measuring window
  input wire logic win_in,
  input wire logic [15:0] pin_in,
  // Results per pin
  output logic [15:0][16:0] high_out,
  output logic [15:0][16:0] chg_out
);
  logic win_q;
  logic [15:0] last;
  // A fresh window restarts the counts, so phase before it does not matter.
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      win_q <= 1'b0;
      last <= 16'h0000;
      high_out <= '0;
      chg_out <= '0;
    end else begin
      win_q <= win_in;
      last <= pin_in;
      for (int i = 0; i < 16; i++) begin
        if (win_in && !win_q) begin
          high_out[i] <= 17'(pin_in[i]);
          chg_out[i] <= 17'(pin_in[i] != last[i]);
        end else if (win_in) begin
          high_out[i] <= high_out[i] + 17'(pin_in[i]);
          chg_out[i] <= chg_out[i] + 17'(pin_in[i] != last[i]);
        end
      end
    end
  end
endmodule : wcg_load
`default_nettype wire

// [wcg_top_sva.sv]
// Port assertions for the compare waveform channel top.
`timescale 1ns/10ps
`default_nettype none
module wcg_top_sva (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Watched ports
  input wire logic [1:0] timer_run_in,
  input wire logic [1:0] timer_tick_in,
  input wire logic [1:0][2:0] counter_clear_sel_in,
  input wire logic [1:0][7:0][2:0] waveform_kind_sel_in,
  input wire logic [1:0][7:0] initial_level_sel_in,
  input wire logic [1:0][7:0] polarity_flip_in,
  input wire logic [1:0][7:0] channel_on_in,
  input wire logic [1:0][7:0] irq_flag_clear_in,
  input wire logic [1:0][15:0] timer_count_out,
  input wire logic [1:0][7:0] match_irq_flag_out,
  input wire logic [1:0][7:0] wave_out_pin_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  sequence s_idle;
    !channel_on_in[0][1] && $stable(initial_level_sel_in[0][1]) && $stable(polarity_flip_in[0][1]);
  endsequence
  sequence s_live;
    channel_on_in[0][2] && $past(channel_on_in[0][2]) && $past(channel_on_in[0][2], 2);
  endsequence
  a_timer_stopped: assert property (!timer_run_in[1] |=> timer_count_out[1] == 16'h0000)
    else $error("timer not held at zero");
  a_timer_step: assert property (timer_run_in[1] && timer_tick_in[1] &&
    counter_clear_sel_in[1] == wcg_pkg::CLEAR_FREE |=> timer_count_out[1] == $past(timer_count_out[1]) + 16'h0001)
    else $error("free timer step wrong");
  a_tick_hold: assert property (timer_run_in[0] && !timer_tick_in[0] |=> $stable(timer_count_out[0]))
    else $error("timer moved without tick");
  a_clear_wrap: assert property (timer_run_in[0] && timer_tick_in[0] &&
    counter_clear_sel_in[0] == wcg_pkg::CLEAR_ON_CH0 |=>
    timer_count_out[0] == $past(timer_count_out[0]) + 16'h0001 || timer_count_out[0] == 16'h0000)
    else $error("cleared timer step wrong");
  a_flag_sticky: assert property (match_irq_flag_out[0][1] && !irq_flag_clear_in[0][1] |=> match_irq_flag_out[0][1])
    else $error("match flag lost");
  a_flag_clear: assert property (irq_flag_clear_in[0][1] && !channel_on_in[0][1] &&
    !$past(channel_on_in[0][1]) |=> !match_irq_flag_out[0][1])
    else $error("match flag not cleared");
  a_flag_cause: assert property ($rose(match_irq_flag_out[0][1]) |->
    $past(timer_run_in[0], 2) && $past(channel_on_in[0][1]))
    else $error("match flag without running channel");
  a_idle_level: assert property (s_idle [*3] |->
    wave_out_pin_out[0][1] == (initial_level_sel_in[0][1] ^ polarity_flip_in[0][1]))
    else $error("disabled pin level wrong");
  a_toggle_cause: assert property (waveform_kind_sel_in[0][2] == wcg_pkg::KIND_TOGGLE &&
    $stable(polarity_flip_in[0][2]) ##0 s_live ##0 $changed(wave_out_pin_out[0][2]) |-> match_irq_flag_out[0][2])
    else $error("toggle without match");
endmodule : wcg_top_sva
bind wcg_top wcg_top_sva u_sva (.clk_in(clk_in), .resetn_in(resetn_in), .timer_run_in(timer_run_in),
  .timer_tick_in(timer_tick_in), .counter_clear_sel_in(counter_clear_sel_in),
  .waveform_kind_sel_in(waveform_kind_sel_in), .initial_level_sel_in(initial_level_sel_in),
  .polarity_flip_in(polarity_flip_in), .channel_on_in(channel_on_in), .irq_flag_clear_in(irq_flag_clear_in),
  .timer_count_out(timer_count_out), .match_irq_flag_out(match_irq_flag_out), .wave_out_pin_out(wave_out_pin_out));
`default_nettype wire

// [compare_waveform_channels_bench.sv]
// Self-checking bench for the compare waveform channel top.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s); end end
module compare_waveform_channels_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] run = '0, tick = '0;
  logic [1:0][2:0] sel = '0;
  logic [1:0][7:0][15:0] cmp = '0;
  logic [1:0][7:0][2:0] kind = '0;
  logic [1:0][7:0] wr = '0, rfr = '0, pick = '0, on = '0, fclr = '0;
  logic [1:0][7:0] init_lvl = {8'h00, 8'h1C}, flip = {8'h00, 8'h18};
  logic [1:0][15:0] cnt;
  logic [1:0][7:0] flag, pin;
  logic win = 1'b0;
  logic [15:0][16:0] hi, chg;
  int n_errors = 0, n_tests = 0;
  int hi0[8] = '{4, 16, 12, 24, 0, 0, 8, 12}, chg0[8] = '{4, 4, 2, 0, 0, 0, 4, 4};
  int hi1[4] = '{49152, 0, 16384, 0}, chg1[4] = '{2, 1, 2, 0};
  always #2 clk = ~clk;
  wcg_top dut (.clk_in(clk), .resetn_in(rst_n), .timer_run_in(run), .timer_tick_in(tick),
    .counter_clear_sel_in(sel), .compare_value_in(cmp), .compare_write_in(wr), .waveform_kind_sel_in(kind),
    .initial_level_sel_in(init_lvl), .polarity_flip_in(flip), .compare_refresh_timing_in(rfr),
    .function_pick_in(pick), .channel_on_in(on), .irq_flag_clear_in(fclr), .timer_count_out(cnt),
    .match_irq_flag_out(flag), .wave_out_pin_out(pin));
  wcg_load load (.clk_in(clk), .resetn_in(rst_n), .win_in(win), .pin_in(pin), .high_out(hi), .chg_out(chg));
  task automatic measure(input int n);
    @(posedge clk);
    win <= 1'b1;
    repeat (n) @(posedge clk);
    win <= 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : measure
  task automatic t_reset;
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK("reset pins", 3'b001, pin[0][4:2])
    `CHK("reset count", 16'h0000, cnt[0])
    `CHK("reset flags", 8'h00, flag[0])
  endtask : t_reset
  task automatic t_run;
    @(posedge clk);
    // The base timer clear selection goes in before any channel setting; run and tick come last.
    sel <= {wcg_pkg::CLEAR_FREE, wcg_pkg::CLEAR_ON_CH0};
    @(posedge clk);
    cmp[0] <= {16'h6, 16'h2, 16'h3, 16'hC, 16'hC, 16'h4, 16'h4, 16'hA};
    kind[0] <= {3'h0, 3'h2, 3'h3, 3'h1, 3'h0, 3'h1, 3'h0, 3'h0};
    cmp[1][3:0] <= {16'h5, 16'h4000, 16'h5, 16'h4000};
    kind[1][1] <= wcg_pkg::KIND_TOGGLE;
    flip[1][2] <= 1'b1;
    // Channel 3 of group 1 is picked away from the waveform function, so it stays inactive.
    pick[1][3] <= 1'b1;
    rfr[0][1] <= wcg_pkg::REFRESH_AT_ZERO;
    wr <= '1;
    @(posedge clk);
    wr <= '0;
    on <= {8'h0F, 8'hFF};
    @(posedge clk);
    run <= 2'h3;
    tick <= 2'h3;
    repeat (60) @(posedge clk);
    measure(24);
    for (int c = 0; c < 8; c++) begin
      `CHK("g0 high", 17'(hi0[c]), hi[c])
      `CHK("g0 changes", 17'(chg0[c]), chg[c])
    end
    `CHK("g0 flags", 8'hE7, flag[0])
    measure(65536);
    for (int c = 0; c < 4; c++) begin
      if (c != 1) `CHK("g1 high", 17'(hi1[c]), hi[8 + c])
      `CHK("g1 changes", 17'(chg1[c]), chg[8 + c])
    end
    `CHK("g1 flags", 8'h07, flag[1])
  endtask : t_run
  task automatic t_disable;
    @(posedge clk);
    on[0][1] <= 1'b0;
    init_lvl[0][1] <= 1'b1;
    tick[0] <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    `CHK("idle pin", 1'b1, pin[0][1])
    @(posedge clk);
    flip[0][1] <= 1'b1;
    fclr[0][1] <= 1'b1;
    @(posedge clk);
    fclr[0][1] <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK("flipped idle pin", 1'b0, pin[0][1])
    `CHK("cleared flag", 1'b0, flag[0][1])
    @(posedge clk);
    tick[0] <= 1'b1;
  endtask : t_disable
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_run();
    t_disable();
    summarize();
  end
endmodule : compare_waveform_channels_bench
`default_nettype wire
